// ### design/ocsc_top.sv
// Output clamp and standby control: clamp register, first standby config
// register, amp switch pin and six hold outputs.
// Assumes register strobes synchronous to SYS_CLK, one cycle each.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ocsc_top (
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST,
  input  wire logic                          CE,
  input  wire logic [ocsc_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [ocsc_pkg::DATA_W-1:0]   WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic      [ocsc_pkg::DATA_W-1:0]   RDATA,
  input  wire logic                          FIRST_STANDBY_INPUT,
  output logic                               AMP_SWITCH_OUT,
  output logic      [ocsc_pkg::NUM_HOLD-1:0] HOLD_OUT
);
  import ocsc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [CLAMP_RSVD_W-1:0] clamp_rsvd_reg;
  logic [DATA_W-1:0]       standby_cfg_reg;
  logic [DATA_W-1:0]       rdata_reg;
  logic [DATA_W-1:0]       rdata_next;
  logic [NUM_CHAN-1:0]     safe;
  logic [NUM_CHAN-1:0]     slept;
  logic [NUM_CHAN-1:0]     wr_safe;
  logic                    sleep_lvl;
  logic                    sleep_fall;
  logic                    wr_clamp;
  logic                    wr_cfg;

  // Builds the clamp register image; bit 6 is the inverted live pin state
  function automatic logic [DATA_W-1:0] clamp_image(
    input logic [CLAMP_RSVD_W-1:0] rsvd,
    input logic [NUM_CHAN-1:0]     s
  );
    clamp_image = {rsvd, ~s[AMP_BIT], s[NUM_HOLD-1:0]};
  endfunction

  // True for a strobe aimed at the given register
  function automatic logic hits(
    input logic              strobe,
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] target
  );
    hits = strobe && (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Standby input synchroniser
  // ----------------------------------------------------------------
  ocsc_sync u_sync (
    .clk      (SYS_CLK),
    .rst      (RST),
    .ce       (CE),
    .async_in (FIRST_STANDBY_INPUT),
    .level_q  (sleep_lvl),
    .fall_q   (sleep_fall)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign wr_clamp = hits(WR, ADDR, CLAMP_ADDR);
  assign wr_cfg   = hits(WR, ADDR, STANDBY1_ADDR);

  // Reserved clamp bits just store what software writes
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      clamp_rsvd_reg <= CLAMP_RSVD_RST;
    end else if (CE && wr_clamp) begin
      clamp_rsvd_reg <= WDATA[DATA_W-1:CLAMP_RSVD_LSB];
    end
  end

  // Standby config: enables low byte, wake policies high byte
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      standby_cfg_reg <= STANDBY1_RESET;
    end else if (CE && wr_cfg) begin
      standby_cfg_reg <= WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Hold bits store the safe value directly; the amp bit is inverted
  // because a written 1 means ON, which is the non-safe state.
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      if (g == AMP_BIT) begin : g_amp
        assign wr_safe[g] = ~WDATA[g];
      end else begin : g_hold
        assign wr_safe[g] = WDATA[g];
      end
      ocsc_chan u_chan (
        .clk        (SYS_CLK),
        .rst        (RST),
        .ce         (CE),
        .sleep_lvl  (sleep_lvl),
        .sleep_fall (sleep_fall),
        .enable     (standby_cfg_reg[g]),
        .policy     (standby_cfg_reg[POLICY_LSB+g]),
        .wr_en      (wr_clamp),
        .wr_safe    (wr_safe[g]),
        .safe_q     (safe[g]),
        .slept_q    (slept[g])
      );
    end
  endgenerate

  // Pin high means OFF; outputs come straight from channel flops
  assign AMP_SWITCH_OUT = safe[AMP_BIT];
  assign HOLD_OUT       = safe[NUM_HOLD-1:0];

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero; data stand one cycle only
  always_comb begin
    rdata_next = '0;
    if (hits(RD, ADDR, CLAMP_ADDR)) begin
      rdata_next = clamp_image(clamp_rsvd_reg, safe);
    end else if (hits(RD, ADDR, STANDBY1_ADDR)) begin
      rdata_next = standby_cfg_reg;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= '0;
    end else if (CE) begin
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Every check lives in the one clock domain; reset aborts attempts
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // Config fields pulled out once so the properties stay short
  logic                amp_en;
  logic                amp_pol;
  logic [NUM_HOLD-1:0] hold_en;
  logic [NUM_HOLD-1:0] hold_pol;
  assign amp_en   = standby_cfg_reg[AMP_BIT];
  assign amp_pol  = standby_cfg_reg[AMP_POLICY_BIT];
  assign hold_en  = standby_cfg_reg[NUM_HOLD-1:0];
  assign hold_pol = standby_cfg_reg[POLICY_LSB+NUM_HOLD-1:POLICY_LSB];

  // ----------------------------------------------------------------
  // Register bus checks
  // ----------------------------------------------------------------
  // Bit 6 read shows the inverted pin, so standby-driven changes are visible
  a_amp_read_live: assert property (
    (CE && hits(RD, ADDR, CLAMP_ADDR)) |=> (RDATA[AMP_BIT] == !$past(AMP_SWITCH_OUT)))
    else $error("amp bit read does not match the pin");

  // Data pulse lasts one cycle; idle edges return the bus to zero
  a_rdata_idle: assert property (
    (CE && !RD) |=> (RDATA == '0))
    else $error("read data not zero after an idle cycle");

  // Stored config comes back on a read right after the write
  a_cfg_readback: assert property (
    (CE && wr_cfg) ##1 (CE && hits(RD, ADDR, STANDBY1_ADDR) && !wr_cfg)
      |=> (RDATA == $past(WDATA, 2)))
    else $error("standby config readback wrong");

  // Reserved clamp bits are plain storage and must read back
  a_clamp_rsvd_keep: assert property (
    (CE && wr_clamp) ##1 (CE && hits(RD, ADDR, CLAMP_ADDR) && !wr_clamp)
      |=> (RDATA[DATA_W-1:CLAMP_RSVD_LSB] == $past(WDATA[DATA_W-1:CLAMP_RSVD_LSB], 2)))
    else $error("reserved clamp bits not kept");

  // Frozen clock enable holds every output, read data included
  a_freeze_pins: assert property (
    !CE |=> ($stable(AMP_SWITCH_OUT) && $stable(HOLD_OUT)))
    else $error("pins moved while clock enable low");

  a_freeze_rdata: assert property (
    !CE |=> $stable(RDATA))
    else $error("read data moved while clock enable low");

  // ----------------------------------------------------------------
  // Software control of the pins
  // ----------------------------------------------------------------
  // A write moves the amp pin unless standby holds it OFF
  a_amp_write_pin: assert property (
    (CE && wr_clamp && !(sleep_lvl && amp_en)) |=> (AMP_SWITCH_OUT == !$past(WDATA[AMP_BIT])))
    else $error("amp pin does not follow the written bit");

  // With standby low a write lands on all six hold outputs
  a_hold_write_val: assert property (
    (CE && wr_clamp && !sleep_lvl) |=> (HOLD_OUT == $past(WDATA[NUM_HOLD-1:0])))
    else $error("hold outputs do not follow the write");

  // Amp pin ignores standby when its enable is clear
  a_amp_ignores: assert property (
    (CE && !amp_en && !wr_clamp) |=> $stable(AMP_SWITCH_OUT))
    else $error("amp pin moved without enable or write");

  // Outputs without a standby enable only move on a write
  a_hold_ignores: assert property (
    (CE && !wr_clamp)
      |=> (((HOLD_OUT ^ $past(HOLD_OUT)) & ~$past(hold_en)) == '0))
    else $error("output moved without enable or write");

  // ----------------------------------------------------------------
  // Standby entry
  // ----------------------------------------------------------------
  // Level lags the pin by exactly two enabled edges
  a_level_synced: assert property (
    (CE ##1 CE) |=> (sleep_lvl == $past(FIRST_STANDBY_INPUT, 2)))
    else $error("standby level not two edges behind the pin");

  // Every enabled output is clamped one edge after the level rises
  a_standby_clamps: assert property (
    (CE && sleep_lvl) |=> ((HOLD_OUT & $past(hold_en)) == $past(hold_en)))
    else $error("enabled output not clamped in standby");

  // Once clamped by standby, the hold bits read back as 1
  a_clamp_bit_set: assert property (
    (CE && sleep_lvl && $past(CE && sleep_lvl) && $stable(hold_en)
      && hits(RD, ADDR, CLAMP_ADDR))
      |=> ((RDATA[NUM_HOLD-1:0] & $past(hold_en)) == $past(hold_en)))
    else $error("clamp bit reads 0 while standby clamps");

  // Amp pin is forced OFF while standby holds
  a_amp_standby_off: assert property (
    (CE && sleep_lvl && amp_en) |=> AMP_SWITCH_OUT)
    else $error("amp not OFF in standby");

  // ----------------------------------------------------------------
  // Standby exit
  // ----------------------------------------------------------------
  // A write in the fall cycle beats the automatic wake, so writes are excluded
  // Policy 0 and a standby-made OFF: the fall alone restores ON
  a_amp_wake_direct: assert property (
    (CE && sleep_fall && slept[AMP_BIT] && amp_en && !amp_pol && !wr_clamp)
      |=> !AMP_SWITCH_OUT)
    else $error("amp did not wake when standby fell");

  // Policy 1: the fall leaves the amp OFF for software to restore
  a_amp_snooze_hold: assert property (
    (CE && sleep_fall && amp_pol && AMP_SWITCH_OUT && !wr_clamp) |=> AMP_SWITCH_OUT)
    else $error("amp woke despite wake policy");

  // Policy 1 outputs stay clamped across the fall
  a_hold_snooze: assert property (
    (CE && sleep_fall && !wr_clamp)
      |=> ((HOLD_OUT & $past(hold_pol & HOLD_OUT)) == $past(hold_pol & HOLD_OUT)))
    else $error("output released despite wake policy");

  // Policy 0 outputs clamped by standby are released by the fall
  a_hold_wake: assert property (
    (CE && sleep_fall && !wr_clamp)
      |=> ((HOLD_OUT & $past(slept[NUM_HOLD-1:0] & hold_en & ~hold_pol)) == '0))
    else $error("output not released when standby fell");

  // ----------------------------------------------------------------
  // Scenario covers
  // ----------------------------------------------------------------
  // Main paths the bench must reach
  c_amp_wake: cover property (
    CE && sleep_fall && slept[AMP_BIT] && !amp_pol ##1 !AMP_SWITCH_OUT);
  c_hold_snooze: cover property (
    CE && sleep_fall && (hold_pol & HOLD_OUT) != '0);
  c_clamp_read: cover property (
    CE && sleep_lvl && hits(RD, ADDR, CLAMP_ADDR));
  c_amp_snooze: cover property (
    CE && sleep_fall && amp_pol && AMP_SWITCH_OUT);
  c_back_to_back: cover property (
    (CE && wr_cfg) ##1 (CE && hits(RD, ADDR, STANDBY1_ADDR)));

endmodule
`default_nettype wire

// ### design/ocsc_pkg.sv
// Shared constants for the output clamp and standby control block.
// Assumes an 8-bit register address and 16-bit register data.
package ocsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned    ADDR_W          = 8;
  localparam int unsigned    DATA_W          = 16;
  localparam logic [7:0]     CLAMP_ADDR      = 8'h17;
  localparam logic [7:0]     STANDBY1_ADDR   = 8'h18;
  localparam logic [15:0]    CLAMP_RESET     = 16'h003F;
  localparam logic [15:0]    STANDBY1_RESET  = 16'hFF00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned    NUM_HOLD        = 6;   // Four aux outputs, two bipolar pairs
  localparam int unsigned    NUM_CHAN        = 7;   // Hold channels plus the amp switch
  localparam int unsigned    AMP_BIT         = 6;   // Amp bit in both registers
  localparam int unsigned    POLICY_LSB      = 8;   // Wake policy field base
  localparam int unsigned    AMP_POLICY_BIT  = 14;
  localparam int unsigned    CLAMP_RSVD_LSB  = 7;   // Clamp bits 15..7 reserved
  localparam int unsigned    CLAMP_RSVD_W    = 9;
  localparam logic [8:0]     CLAMP_RSVD_RST  = 9'h000;

  // Channel order within the hold field
  localparam int unsigned    PAIR_A_BIT      = 0;
  localparam int unsigned    PAIR_B_BIT      = 1;
  localparam int unsigned    AUX1_BIT        = 2;
  localparam int unsigned    AUX4_BIT        = 5;

endpackage

// ### design/ocsc_sync.sv
// Two-stage synchroniser with edge history for the standby input.
// Assumes the input is asynchronous to SYS_CLK; CE freezes all stages.
`timescale 1ns/1ps
`default_nettype none
module ocsc_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      level_q,
  output logic      fall_q
);

  logic meta_reg;
  logic level_reg;
  logic prev_reg;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // Only the second stage reads the first stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg  <= 1'b0;
      level_reg <= 1'b0;
    end else if (ce) begin
      meta_reg  <= async_in;
      level_reg <= meta_reg;
    end
  end

  // History of the clean level for falling-edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= 1'b0;
    end else if (ce) begin
      prev_reg <= level_reg;
    end
  end

  assign level_q = level_reg;
  assign fall_q  = prev_reg & ~level_reg;

endmodule
`default_nettype wire

// ### design/ocsc_chan.sv
// One standby-controlled channel: a "safe" state bit (clamped, or amp OFF).
// Assumes a synchronised standby level and its falling pulse as inputs.
`timescale 1ns/1ps
`default_nettype none
module ocsc_chan (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic sleep_lvl,
  input  wire logic sleep_fall,
  input  wire logic enable,
  input  wire logic policy,
  input  wire logic wr_en,
  input  wire logic wr_safe,
  output logic      safe_q,
  output logic      slept_q
);

  logic safe_reg;
  logic slept_reg;

  // ----------------------------------------------------------------
  // Safe state
  // ----------------------------------------------------------------
  // Standby wins over a same-cycle write so a clamp is never lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      safe_reg <= 1'b1;
    end else if (ce) begin
      if (sleep_lvl && enable) begin
        safe_reg <= 1'b1;
      end else if (wr_en) begin
        safe_reg <= wr_safe;
      end else if (sleep_fall && slept_reg && enable && !policy) begin
        safe_reg <= 1'b0;
      end
    end
  end

  // Marks that standby, not software, made the channel safe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slept_reg <= 1'b0;
    end else if (ce) begin
      if (sleep_lvl && enable) begin
        slept_reg <= 1'b1;
      end else if (sleep_fall || wr_en) begin
        slept_reg <= 1'b0;
      end
    end
  end

  assign safe_q  = safe_reg;
  assign slept_q = slept_reg;

endmodule
`default_nettype wire

// ### dv/ocsc_standby_src.sv
// Far-side model: the board logic that drives the standby input pin.
// Assumes the bench asks for a level; the pin moves well off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module ocsc_standby_src (
  input  wire logic clk,
  input  wire logic want,
  output logic      pin
);
  // ------------------------------------------------------------
  // Pin driver
  // ------------------------------------------------------------
  // Late change keeps the pin asynchronous to the sampling edge
  initial pin = 1'b0;
  always @(posedge clk) begin
    pin <= #37 want;
  end
endmodule
`default_nettype wire

// ### dv/tb_ocsc_top.sv
// Self-checking bench for the clamp and standby control block.
// Assumes ocsc_pkg is compiled first; CE drops only in the freeze scenario.
`timescale 1ns/1ps
`default_nettype none
module tb_ocsc_top;
  import ocsc_pkg::*;
  logic              sys_clk = 1'b0;
  logic              rst     = 1'b1;
  logic              ce      = 1'b1;
  logic [7:0]        addr    = 8'h00;
  logic [15:0]       wdata   = 16'h0000;
  logic              wr      = 1'b0;
  logic              rd      = 1'b0;
  logic [15:0]       rdata;
  logic              sb_want = 1'b0;
  logic              sb_pin;
  logic              amp_out;
  logic [5:0]        hold;
  int                failures   = 0;
  int                num_checks = 0;

  // ------------------------------------------------------------
  // Clock, design and far side
  // ------------------------------------------------------------
  always #50 sys_clk = ~sys_clk;
  ocsc_top i_ocsc_top (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .FIRST_STANDBY_INPUT(sb_pin),
    .AMP_SWITCH_OUT(amp_out), .HOLD_OUT(hold));
  ocsc_standby_src i_ocsc_standby_src (.clk(sys_clk), .want(sb_want), .pin(sb_pin));

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    cmp_reg(a, exp);
  endtask
  // Write, then read with no gap between the strobes
  task automatic wr_rd_reg(input logic [7:0] a, input logic [15:0] d,
                           input logic [15:0] exp);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge sys_clk);
    rd    <= 1'b0;
    #1;
    cmp_reg(a, exp);
  endtask
  // One compare for every register read result
  task automatic cmp_reg(input logic [7:0] a, input logic [15:0] exp);
    num_checks++;
    if (rdata !== exp) begin
      failures++;
      $display("BAD t=%0t reg %h got %h exp %h", $time, a, rdata, exp);
    end
  endtask
  // Pins as {amp switch, six hold outputs}
  task automatic chk_pins(input logic [6:0] exp);
    num_checks++;
    if ({amp_out, hold} !== exp) begin
      failures++;
      $display("BAD t=%0t pins got %h exp %h", $time, {amp_out, hold}, exp);
    end
  endtask
  // Bounded wait; a miss is a mismatch and ends the run
  task automatic wait_pins(input logic [6:0] exp, input int n);
    for (int i = 0; i < n; i++) begin
      if ({amp_out, hold} === exp) break;
      @(posedge sys_clk);
      #1;
    end
    chk_pins(exp);
    if ({amp_out, hold} !== exp) give_verdict();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk_pins(7'h7F);
    chk_reg(CLAMP_ADDR, 16'h003F);
    chk_reg(STANDBY1_ADDR, 16'hFF00);
  endtask
  task automatic t_direct;
    wr_reg(8'h20, 16'h0000);
    chk_reg(8'h20, 16'h0000);
    wr_reg(CLAMP_ADDR, 16'h0040);
    chk_pins(7'h00);
    chk_reg(CLAMP_ADDR, 16'h0040);
    wr_reg(CLAMP_ADDR, 16'h0024);
    chk_pins(7'h64);
    wr_reg(CLAMP_ADDR, 16'h0040);
    chk_pins(7'h00);
  endtask
  // Policies 0: standby forces safe, its fall wakes directly
  task automatic t_auto_wake;
    wr_reg(STANDBY1_ADDR, 16'h0041);
    sb_want <= 1'b1;
    idle(3);
    chk_pins(7'h00);
    wait_pins(7'h41, 4);
    chk_reg(CLAMP_ADDR, 16'h0001);
    sb_want <= 1'b0;
    wait_pins(7'h00, 6);
    chk_reg(CLAMP_ADDR, 16'h0040);
  endtask
  // Policies 1: outputs stay safe until software writes
  task automatic t_snooze;
    wr_reg(STANDBY1_ADDR, 16'h4242);
    sb_want <= 1'b1;
    wait_pins(7'h42, 6);
    sb_want <= 1'b0;
    idle(10);
    chk_pins(7'h42);
    chk_reg(CLAMP_ADDR, 16'h0002);
    wr_reg(CLAMP_ADDR, 16'h0040);
    chk_pins(7'h00);
  endtask
  // Enables clear: standby input has no effect
  task automatic t_ignored;
    wr_reg(STANDBY1_ADDR, 16'h0000);
    sb_want <= 1'b1;
    idle(8);
    chk_pins(7'h00);
    sb_want <= 1'b0;
    idle(8);
    chk_reg(CLAMP_ADDR, 16'h0040);
  endtask
  // Back-to-back strobes; reserved bits are stored
  task automatic t_back_to_back;
    wr_rd_reg(STANDBY1_ADDR, 16'h8000, 16'h8000);
    wr_rd_reg(CLAMP_ADDR, 16'h8024, 16'h8024);
    chk_pins(7'h64);
  endtask
  // Clock enable low: a write is dropped and every output holds
  task automatic t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    wr_reg(CLAMP_ADDR, 16'h0040);
    idle(2);
    chk_pins(7'h64);
    @(posedge sys_clk);
    ce <= 1'b1;
    chk_reg(CLAMP_ADDR, 16'h8024);
  endtask

  // ------------------------------------------------------------
  // Verdict and main sequence
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    idle(1);
    t_reset();
    t_direct();
    t_auto_wake();
    t_snooze();
    t_ignored();
    t_back_to_back();
    t_freeze();
    give_verdict();
  end
endmodule
`default_nettype wire
